// ---- rtl/fir_transversal_mac_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fir_regs.svh"

module fir_transversal_mac_sequencer #(
    parameter int TAPS = `FIR_TAPS,
    parameter int FIFO_DEPTH = `FIR_FIFO_DEPTH
) (
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire fir_pkg::sample_t SAMPLE_IN,
    input wire logic SAMPLE_VALID,
    output logic SAMPLE_READY,
    input wire fir_pkg::coef_t COEF_IN,
    input wire logic COEF_LOAD,
    output fir_pkg::acc_t RESULT,
    output logic RESULT_VALID
);
    import fir_pkg::*;

    localparam int RING = TAPS - 1;
    localparam int PW = $clog2(TAPS);

    generate
        if (TAPS < 2)
        begin : g_bad_taps
            $error("filter needs at least two taps");
        end
        if (`FIR_CLK_PERIOD_NS < `FIR_MAC_TIME_NS || `FIR_MAC_TIME_CYC != 1)
        begin : g_bad_clock
            $error("clock period shorter than the multiply-accumulate time");
        end
        if (FIFO_DEPTH < 2 || (1 << $clog2(FIFO_DEPTH)) != FIFO_DEPTH)
        begin : g_bad_depth
            $error("input buffer depth must be a power of two of at least 2");
        end
        if (`FIR_ACC_W < `FIR_SAMPLE_W + `FIR_COEF_W + $clog2(TAPS))
        begin : g_bad_acc
            $error("accumulator too narrow for the tap count");
        end
    endgenerate

    sample_stream_if #(.W(`FIR_SAMPLE_W)) fifo_out ();
    mac_op_if #(.XW(`FIR_SAMPLE_W), .YW(`FIR_COEF_W)) op ();

    // Input buffer; its ready reaches the source as back-pressure
    sample_fifo #(
        .W(`FIR_SAMPLE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(CLK_SYS),
        .srst(SRST),
        .wr_data(SAMPLE_IN),
        .wr_valid(SAMPLE_VALID),
        .wr_ready(SAMPLE_READY),
        .rd(fifo_out.src)
    );

    // The single multiply-accumulate unit does every product and sum
    mac_unit #(
        .XW(`FIR_SAMPLE_W),
        .YW(`FIR_COEF_W),
        .AW(`FIR_ACC_W)
    ) u_mac (
        .clk(CLK_SYS),
        .srst(SRST),
        .op(op.mac),
        .result(RESULT),
        .result_valid(RESULT_VALID)
    );

    seq_state_t state_ff;
    logic [PW-1:0] phase_ff;
    sample_t data_ring_ff [RING];
    coef_t coef_ring_ff [TAPS];
    sample_t x_ff;
    coef_t y_ff;
    logic go_ff;
    logic keep_ff;
    logic last_ff;
    logic start;
    logic step;
    logic coef_shift;
    logic cycle_end;

    // Sequence controller
    assign start = (state_ff == ST_WAIT) && fifo_out.valid && !COEF_LOAD;
    assign step = start || (state_ff == ST_RING);
    assign coef_shift = (state_ff == ST_WAIT) && COEF_LOAD;
    assign cycle_end = (state_ff == ST_RING) && (phase_ff == PW'(TAPS - 1));
    assign fifo_out.ready = start;

    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
        begin
            state_ff <= ST_WAIT;
            phase_ff <= '0;
        end
        else
        begin
            unique case (state_ff)
                ST_WAIT:
                begin
                    if (start)
                    begin
                        state_ff <= ST_RING;
                        phase_ff <= PW'(1);
                    end
                end
                ST_RING:
                begin
                    if (cycle_end)
                    begin
                        state_ff <= ST_WAIT;
                        phase_ff <= '0;
                    end
                    else
                        phase_ff <= phase_ff + PW'(1);
                end
                default:
                begin
                    state_ff <= ST_WAIT;
                    phase_ff <= '0;
                end
            endcase
        end
    end

    // Data ring: entry takes the new sample on the first clock, else the last stage
    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
            data_ring_ff[0] <= `FIR_STAGE_RST;
        else if (step)
            data_ring_ff[0] <= start ? sample_t'(fifo_out.data) : data_ring_ff[RING-1];
    end

    // Coefficient ring: closed on every step, preload shifts words in while waiting
    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
            coef_ring_ff[0] <= `FIR_STAGE_RST;
        else if (coef_shift)
            coef_ring_ff[0] <= COEF_IN;
        else if (step)
            coef_ring_ff[0] <= coef_ring_ff[TAPS-1];
    end

    generate
        for (genvar i = 1; i < TAPS; i++)
        begin : g_stage
            if (i < RING)
            begin : g_data
                always_ff @(posedge CLK_SYS)
                begin
                    if (SRST)
                        data_ring_ff[i] <= `FIR_STAGE_RST;
                    else if (step)
                        data_ring_ff[i] <= data_ring_ff[i-1];
                end
            end
            always_ff @(posedge CLK_SYS)
            begin
                if (SRST)
                    coef_ring_ff[i] <= `FIR_STAGE_RST;
                else if (step || coef_shift)
                    coef_ring_ff[i] <= coef_ring_ff[i-1];
            end
        end
    endgenerate

    // Operand registers: last stages feed the multiplier
    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
        begin
            x_ff <= `FIR_STAGE_RST;
            y_ff <= `FIR_STAGE_RST;
        end
        else if (step)
        begin
            x_ff <= data_ring_ff[RING-1];
            y_ff <= coef_ring_ff[TAPS-1];
        end
    end

    // MAC controls follow the sequencer one clock later
    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
        begin
            go_ff <= 1'b0;
            keep_ff <= 1'b0;
            last_ff <= 1'b0;
        end
        else
        begin
            go_ff <= step;
            keep_ff <= step && !start;
            last_ff <= cycle_end;
        end
    end

    assign op.x = x_ff;
    assign op.y = y_ff;
    assign op.go = go_ff;
    assign op.keep = keep_ff;
    assign op.last = last_ff;

    // Clocks since the last output, saturating, for the spacing check
    logic [PW:0] gap_ff;
    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
            gap_ff <= '1;
        else if (RESULT_VALID)
            gap_ff <= (PW+1)'(1);
        else if (gap_ff != '1)
            gap_ff <= gap_ff + (PW+1)'(1);
    end

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (SRST);

    a_feed_only_wait: assert property (fifo_out.ready |-> state_ff == ST_WAIT && fifo_out.valid)
        else $error("new sample taken outside the first clock");
    a_cycle_wraps: assert property (cycle_end |=> state_ff == ST_WAIT && phase_ff == '0)
        else $error("filter cycle did not end after N clocks");
    a_cycle_length: assert property (start |=> (state_ff == ST_RING)[*7])
        else $error("filter cycle shorter than N clocks");
    a_keep_first_low: assert property (start |=> go_ff && !keep_ff)
        else $error("accumulate control high on first clock");
    a_keep_rest_high: assert property (start |=> ##1 (go_ff && keep_ff)[*7])
        else $error("accumulate control low inside the cycle");
    a_result_time: assert property (start |-> ##9 RESULT_VALID)
        else $error("output missing nine clocks after start");
    a_result_spacing: assert property (RESULT_VALID |=> !RESULT_VALID[*7])
        else $error("outputs closer than eight clocks");
    a_x_from_last: assert property (step |=> x_ff == $past(data_ring_ff[RING-1]))
        else $error("first operand not from data last stage");
    a_y_from_last: assert property (step |=> y_ff == $past(coef_ring_ff[TAPS-1]))
        else $error("second operand not from coefficient last stage");
    a_new_entry: assert property (start |=> data_ring_ff[0] == $past(sample_t'(fifo_out.data)))
        else $error("new sample not in data entry stage");
    a_ring_rotate: assert property (state_ff == ST_RING |=> data_ring_ff[0] == $past(data_ring_ff[RING-1]))
        else $error("data ring not closed");
    a_coef_returns: assert property (start |-> ##8 coef_ring_ff[0] == $past(coef_ring_ff[0], 8))
        else $error("coefficient ring not back after N clocks");
    a_idle_hold: assert property (!step && !coef_shift |=> $stable(coef_ring_ff[TAPS-1]) && !go_ff)
        else $error("pipeline moved while idle");
    a_data_idle: assert property (!step |=> $stable(data_ring_ff[RING-1]) && $stable(x_ff))
        else $error("data pipeline moved while idle");
    a_state_onehot: assert property ($onehot(state_ff))
        else $error("sequencer state not one-hot");
    a_phase_range: assert property (phase_ff <= PW'(TAPS - 1))
        else $error("phase counter beyond the filter cycle");
    a_take_once: assert property (start |=> !fifo_out.ready[*7])
        else $error("second sample taken inside a filter cycle");
    a_last_with_keep: assert property (last_ff |-> go_ff && keep_ff)
        else $error("last product not accumulated");

    // Output and coefficient checks
    a_result_gap: assert property (RESULT_VALID |-> gap_ff >= (PW+1)'(TAPS))
        else $error("outputs closer than one filter cycle");
    a_result_after_last: assert property (RESULT_VALID |-> $past(last_ff))
        else $error("output without a last product");
    a_result_hold: assert property (!RESULT_VALID |-> $stable(RESULT))
        else $error("output changed without a valid pulse");
    a_coef_shift_in: assert property (coef_shift |=> coef_ring_ff[0] == $past(COEF_IN))
        else $error("coefficient word not in entry stage");
    a_load_first: assert property (COEF_LOAD |-> !fifo_out.ready)
        else $error("filter cycle started during a coefficient load");
    a_load_ignored: assert property (state_ff == ST_RING && COEF_LOAD |=>
        coef_ring_ff[0] == $past(coef_ring_ff[TAPS-1]))
        else $error("coefficient load taken during a filter cycle");

    c_start: cover property (start);
    c_back_to_back: cover property (RESULT_VALID ##8 RESULT_VALID);
    c_coef_preload: cover property (coef_shift[*8]);
    c_fifo_full: cover property (!SAMPLE_READY);
    c_stall: cover property (state_ff == ST_WAIT && !fifo_out.valid);

endmodule : fir_transversal_mac_sequencer

`default_nettype wire

// ---- rtl/fir_regs.svh ----
`ifndef FIR_REGS_SVH
`define FIR_REGS_SVH

// Word widths
`define FIR_SAMPLE_W 16
`define FIR_COEF_W 16
`define FIR_ACC_W 40

// Default tap count and input buffer depth
`define FIR_TAPS 8
`define FIR_FIFO_DEPTH 32

// Timing: multiply-accumulate time and system clock period in ns
`define FIR_MAC_TIME_NS 25
`define FIR_CLK_PERIOD_NS 100
// Least time, rounded up to whole cycles, never below one
`define FIR_MAC_TIME_CYC (((`FIR_MAC_TIME_NS + `FIR_CLK_PERIOD_NS - 1) / `FIR_CLK_PERIOD_NS) < 1 ? 1 : \
    ((`FIR_MAC_TIME_NS + `FIR_CLK_PERIOD_NS - 1) / `FIR_CLK_PERIOD_NS))

// Reset value of every data and coefficient stage
`define FIR_STAGE_RST 16'h0000

`endif

// ---- rtl/fir_pkg.sv ----
`include "fir_regs.svh"

package fir_pkg;

    typedef logic signed [`FIR_SAMPLE_W-1:0] sample_t;
    typedef logic signed [`FIR_COEF_W-1:0] coef_t;
    typedef logic signed [`FIR_ACC_W-1:0] acc_t;

    typedef enum logic [1:0] {
        ST_WAIT = 2'b01,
        ST_RING = 2'b10
    } seq_state_t;

endpackage : fir_pkg

// ---- rtl/fir_links.sv ----
`timescale 1ns/1ps
`default_nettype none

// Sample stream from the input buffer to the sequencer
interface sample_stream_if #(parameter int W = 16) ();
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : sample_stream_if

// Operand bundle from the sequencer to the multiply-accumulate unit
interface mac_op_if #(parameter int XW = 16, parameter int YW = 16) ();
    logic [XW-1:0] x;
    logic [YW-1:0] y;
    logic go;
    logic keep;
    logic last;
    modport drv (output x, output y, output go, output keep, output last);
    modport mac (input x, input y, input go, input keep, input last);
endinterface : mac_op_if

`default_nettype wire

// ---- rtl/sample_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none

module sample_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [W-1:0] wr_data,
    input wire logic wr_valid,
    output logic wr_ready,
    sample_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH)
        begin : g_bad_depth
            $error("sample_fifo depth must be a power of two of at least 2");
        end
    endgenerate

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic [AW:0] nxt_count;
    logic ready_ff;
    logic push;
    logic pop;

    assign push = wr_valid && ready_ff;
    assign pop = rd.valid && rd.ready;
    assign wr_ready = ready_ff;
    assign rd.valid = (count_ff != '0);
    assign rd.data = mem[rd_ptr_ff];

    always_comb
    begin
        nxt_count = count_ff;
        if (push && !pop)
            nxt_count = count_ff + (AW+1)'(1);
        else if (pop && !push)
            nxt_count = count_ff - (AW+1)'(1);
    end

    // Storage
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr_ff] <= wr_data;
    end

    // Pointers, fill level and registered ready
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
            ready_ff <= 1'b0;
        end
        else
        begin
            if (push)
                wr_ptr_ff <= wr_ptr_ff + AW'(1);
            if (pop)
                rd_ptr_ff <= rd_ptr_ff + AW'(1);
            count_ff <= nxt_count;
            ready_ff <= (nxt_count != (AW+1)'(DEPTH));
        end
    end

endmodule : sample_fifo

`default_nettype wire

// ---- rtl/mac_unit.sv ----
`timescale 1ns/1ps
`default_nettype none

module mac_unit #(
    parameter int XW = 16,
    parameter int YW = 16,
    parameter int AW = 40
) (
    input wire logic clk,
    input wire logic srst,
    mac_op_if.mac op,
    output logic [AW-1:0] result,
    output logic result_valid
);
    generate
        if (AW < XW + YW)
        begin : g_bad_acc
            $error("mac_unit accumulator narrower than a full product");
        end
    endgenerate

    logic signed [XW+YW-1:0] prod;
    logic signed [AW-1:0] prod_ext;
    logic signed [AW-1:0] acc_ff;
    logic signed [AW-1:0] nxt_acc;
    logic [AW-1:0] result_ff;
    logic done_ff;

    assign prod = $signed(op.x) * $signed(op.y);
    assign prod_ext = AW'(prod);
    // Restart from the product or add onto the running sum
    assign nxt_acc = op.keep ? acc_ff + prod_ext : prod_ext;
    assign result = result_ff;
    assign result_valid = done_ff;

    always_ff @(posedge clk)
    begin
        if (srst)
            acc_ff <= '0;
        else if (op.go)
            acc_ff <= nxt_acc;
    end

    // Completed sum is latched on the last product of a filter cycle
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            result_ff <= '0;
            done_ff <= 1'b0;
        end
        else
        begin
            done_ff <= op.go && op.last;
            if (op.go && op.last)
                result_ff <= nxt_acc;
        end
    end

    a_mac_sum: assert property (@(posedge clk) disable iff (srst)
        op.go && op.keep |=> acc_ff == $past(acc_ff) + $past(prod_ext))
        else $error("accumulator did not add the product");

endmodule : mac_unit

`default_nettype wire

// ---- bench/sample_source.sv ----
`timescale 1ns/1ps
`default_nettype none
// Upstream sample source: offers one word and holds it until taken
module sample_source (
    input wire logic clk,
    input wire logic ready,
    output var fir_pkg::sample_t data,
    output var logic valid
);
    import fir_pkg::*;
    int cyc = 0;
    int t_acc = 0;
    bit saw_full = 1'b0;
    initial
    begin
        data = 16'h5a5a;
        valid = 1'b0;
    end
    always @(posedge clk)
        cyc <= cyc + 1;
    // Called just after an edge; returns just after the accepting edge
    task automatic send(input sample_t v, output bit ok);
        int n;
        n = 0;
        data = v;
        valid = 1'b1;
        while (ready !== 1'b1 && n < 500)
        begin
            saw_full = 1'b1;
            @(posedge clk);
            #1;
            n++;
        end
        t_acc = cyc;
        ok = (n < 500);
        @(posedge clk);
        #1;
    endtask : send
    // Released line shows the inverse of the last word
    task automatic rest();
        valid = 1'b0;
        data = ~data;
    endtask : rest
endmodule : sample_source
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    import fir_pkg::*;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    sample_t sample_in;
    logic sample_valid;
    logic sample_ready;
    coef_t coef_in = 16'h0000;
    logic coef_load = 1'b0;
    acc_t result;
    logic result_valid;
    int n_mismatch = 0;
    int check_count = 0;
    int seed = 68;
    coef_t cf[8];
    sample_t hist[$];
    int pt[$];
    int oi = 0;
    int i;
    int b;
    bit ok;

    always #50 clk_sys = ~clk_sys;

    fir_transversal_mac_sequencer dut_u (.CLK_SYS(clk_sys), .SRST(srst), .SAMPLE_IN(sample_in),
        .SAMPLE_VALID(sample_valid), .SAMPLE_READY(sample_ready), .COEF_IN(coef_in), .COEF_LOAD(coef_load),
        .RESULT(result), .RESULT_VALID(result_valid));
    sample_source src_u (.clk(clk_sys), .ready(sample_ready), .data(sample_in), .valid(sample_valid));

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize

    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Weighted sum of the current and seven earlier samples, zero before start
    function automatic acc_t expect_out(input int n);
        acc_t s;
        s = '0;
        for (int j = 0; j < 8; j++)
            if (n - j >= 0)
                s += acc_t'(cf[j]) * acc_t'(hist[n - j]);
        return s;
    endfunction : expect_out

    always @(posedge clk_sys)
        if (result_valid === 1'b1)
        begin
            check(result, expect_out(oi));
            pt.push_back(src_u.cyc);
            oi <= oi + 1;
        end

    task automatic do_reset();
        srst = 1'b1;
        repeat (6) @(posedge clk_sys);
        #1;
        check(sample_ready, 1'b0);
        check(result_valid, 1'b0);
        check(result, 40'h0);
        hist.delete();
        pt.delete();
        oi = 0;
        srst = 1'b0;
    endtask : do_reset

    // Coefficients shifted in last tap first, one per clock
    task automatic load(input bit rnd);
        for (int j = 7; j >= 0; j--)
        begin
            cf[j] = rnd ? coef_t'($random(seed)) : 16'h8000;
            coef_in = cf[j];
            coef_load = 1'b1;
            @(posedge clk_sys);
            #1;
        end
        coef_load = 1'b0;
    endtask : load

    task automatic put(input sample_t v);
        hist.push_back(v);
        src_u.send(v, ok);
        if (!ok)
        begin
            n_mismatch++;
            summarize();
        end
    endtask : put

    task automatic drain();
        int n;
        n = 0;
        while (oi < hist.size() && n < 2000)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (oi < hist.size())
        begin
            n_mismatch++;
            summarize();
        end
    endtask : drain

    initial
    begin
        do_reset();
        // Full-scale taps and samples, history filled from zero
        load(1'b0);
        for (i = 0; i < 10; i++)
            put(i[0] ? 16'h7fff : 16'h8000);
        src_u.rest();
        drain();
        // Lone sample into an idle buffer
        put(16'h0003);
        b = src_u.t_acc;
        src_u.rest();
        drain();
        check(40'(pt[pt.size() - 1] - b), 40'h0a);
        // Mid-run reset, random taps, impulse, eight zeros and one random sample with random gaps
        do_reset();
        load(1'b1);
        for (i = 0; i < 10; i++)
        begin
            put(i == 0 ? 16'h0001 : sample_t'(i > 8 ? $random(seed) : 0));
            src_u.rest();
            repeat (1 + ($unsigned($random(seed)) % 12))
            begin
                @(posedge clk_sys);
                #1;
            end
        end
        drain();
        // Coefficient write while a filter cycle runs is ignored
        put(sample_t'($random(seed)));
        src_u.rest();
        @(posedge clk_sys);
        #1;
        coef_in = ~cf[0];
        coef_load = 1'b1;
        @(posedge clk_sys);
        #1;
        coef_load = 1'b0;
        drain();
        // Back-to-back burst fills the buffer until it refuses, then drains
        b = pt.size();
        src_u.saw_full = 1'b0;
        for (i = 0; i < 45; i++)
            put(sample_t'($random(seed)));
        src_u.rest();
        check(40'(src_u.saw_full), 40'h1);
        drain();
        for (i = b + 1; i < pt.size(); i++)
            check(40'(pt[i] - pt[i - 1]), 40'h8);
        summarize();
    end
endmodule : tb
`default_nettype wire
